/* cpt_defines.svh */
// Register offsets, field positions, reset values and divider ratios of the compact timer.
// Assumes inclusion by its bare name from the package and from the design modules.
`ifndef CPT_DEFINES_SVH
`define CPT_DEFINES_SVH

`define CPT_OFS_CTL0 5'h00
`define CPT_OFS_CTL1 5'h04
`define CPT_OFS_CNT_LO 5'h08
`define CPT_OFS_CNT_HI 5'h0C
`define CPT_OFS_CMPA_LO 5'h10
`define CPT_OFS_CMPA_HI 5'h14

`define CPT_CTL0_RESET 8'h00
`define CPT_CTL1_RESET 8'h00
`define CPT_CMPA_RESET 10'h000
`define CPT_CNT_RESET 10'h000
`define CPT_BUF_RESET 8'h00

`define CPT_CTL0_ON_BIT 3
`define CPT_HI_BITS 2

`define CPT_DIV_SYS 6'h03
`define CPT_DIV_H16 6'h0F
`define CPT_DIV_H64 6'h3F

`define CPT_CLK_SYS_DIV4 3'h0
`define CPT_CLK_SYS 3'h1
`define CPT_CLK_H_DIV16 3'h2
`define CPT_CLK_H_DIV64 3'h3
`define CPT_CLK_SUB_A 3'h4
`define CPT_CLK_SUB_B 3'h5
`define CPT_CLK_EXT_RISE 3'h6
`define CPT_CLK_EXT_FALL 3'h7

`define CPT_IO_LOW 2'h1
`define CPT_IO_HIGH 2'h2
`define CPT_IO_TOGGLE 2'h3
`define CPT_IO_PWM_OFF 2'h0
`define CPT_IO_PWM_ON 2'h1
`define CPT_IO_PWM_RUN 2'h2

`endif

/* cpt_pkg.sv */
// Types shared by the compact timer modules.
// Assumes cpt_defines.svh is on the include path.
`include "cpt_defines.svh"

package cpt_pkg;

	typedef enum logic [1:0] {
		CPT_MODE_CMP = 2'h0,
		CPT_MODE_UNDEF = 2'h1,
		CPT_MODE_PWM = 2'h2,
		CPT_MODE_TIMER = 2'h3
	} cpt_mode_t;

	typedef struct packed {
		logic pause;
		logic [2:0] clk_sel;
		logic on;
		logic [2:0] period_compare_bits;
	} cpt_ctl0_t;

	typedef struct packed {
		cpt_mode_t mode_field;
		logic [1:0] out_func;
		logic output_initial_level;
		logic polarity;
		logic duty_swap;
		logic clear_select;
	} cpt_ctl1_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] addr;
	} cpt_ahb_req_t;

	typedef struct packed {
		logic div4;
		logic div16;
		logic div64;
	} cpt_ticks_t;

endpackage

/* cpt_prescaler.sv */
// Free-running divider that gives one-cycle ticks at mclk/4, /16 and /64.
// Assumes the high clock equals mclk, the system clock.
`timescale 1ns/1ps
`default_nettype none

module cpt_prescaler
	import cpt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	output cpt_ticks_t ticks
);

	logic [5:0] div;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			div <= 6'h00;
		else
			div <= div + 6'h01;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			ticks <= '0;
		else
		begin
			ticks.div4 <= (div[1:0] == 2'h3);
			ticks.div16 <= (div[3:0] == 4'hE);
			ticks.div64 <= (div == 6'h3E);
		end
	end

endmodule
`default_nettype wire

/* cpt_sync.sv */
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to mclk.
`timescale 1ns/1ps
`default_nettype none

module cpt_sync
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);

	logic meta;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			meta <= 1'b0;
			dout <= 1'b0;
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule
`default_nettype wire

/* cpt_timer.sv */
// Compact 10-bit timer with two comparators, output pins and an AHB-Lite register slave.
// Assumes one AHB-Lite master, mclk as system and high clock, asynchronous pins for the external and sub clocks.
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpt_defines.svh"

////////////////////////////////////////////////////////////////////////////////

// Function
// - Ten-bit up counter, clocked by the selected source, not loadable by software.
// - Clock select picks sys/4, sys, high/16, high/64, sub, external rise or fall.
// - Comparator P compares three period bits with counter bits nine to seven.
// - Comparator A compares the ten-bit compare value with the whole counter.
// - Separate match requests for A and P; a match may clear counter, move output.
// - Counter clears on overflow or selected match; software only clears via counter-on rise.
// - Inverted output pin always carries the inverse of the true output.
// - Compare mode drives output high, low or toggles on a comparator A match.
// - PWM mode produces the waveform on both output pins.
// - Compare A low write fills the buffer; high write stores both bytes at once.
// - High byte read snapshots the low byte into the buffer; low read returns it.
// - Counter pair is read-only; compare A pair is read and write.
// - Pause holds the counter; releasing pause resumes from the held value.
// - Counter-on low stops and holds; its rise clears the counter to zero.
// - Counter-on rise returns the output to its initial level in compare and PWM.
// - Control zero holds pause, clock select, counter-on, period bits; reset zero.
// - Period code zero means 1024 clocks; code n means n times 128 clocks.
// - Mode field: 00 compare output, 10 PWM, 11 timer; 01 undefined.
// - Outside PWM, clear select one clears on A match, zero on P match or overflow; in PWM duty swap picks instead.
module cpt_timer
	import cpt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ext_clock_pin,
	input wire logic sub_clock_pin,
	output logic timer_out,
	output logic timer_out_n,
	output logic match_a_irq,
	output logic match_p_irq
);

	////////////////////////////////////////////////////////////////////////////////

	cpt_ctl0_t ctl0;
	cpt_ctl1_t ctl1;
	cpt_ahb_req_t dp;
	cpt_ticks_t ticks;
	logic [9:0] counter, compare_a_value;
	logic [7:0] hold_buf, rd_val;
	logic out_lvl, ext_sync, ext_prev, sub_sync, sub_prev, cnt_tick, run, step;
	logic a_hit, p_hit, clr_now, duty_active, wr_en, rd_now, wr_ctl0, on_rise, unused_ok;

	default clocking cpt_cb @(posedge mclk); endclocking
	default disable iff (rst);

	assign unused_ok = ^{hsize, haddr[31:5], haddr[1:0], hwdata[31:8]};

	////////////////////////////////////////////////////////////////////////////////
	// Clock sources.

	cpt_prescaler u_prescaler
	(
		.mclk(mclk),
		.rst(rst),
		.ticks(ticks)
	);

	cpt_sync u_ext_sync
	(
		.mclk(mclk),
		.rst(rst),
		.din(ext_clock_pin),
		.dout(ext_sync)
	);

	cpt_sync u_sub_sync
	(
		.mclk(mclk),
		.rst(rst),
		.din(sub_clock_pin),
		.dout(sub_sync)
	);

	// Edge history looks only at the synchronised levels.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			{ext_prev, sub_prev} <= 2'h0;
		else
			{ext_prev, sub_prev} <= {ext_sync, sub_sync};
	end

	always_comb
	begin
		case (ctl0.clk_sel)
			`CPT_CLK_SYS_DIV4: cnt_tick = ticks.div4;
			`CPT_CLK_SYS: cnt_tick = 1'b1;
			`CPT_CLK_H_DIV16: cnt_tick = ticks.div16;
			`CPT_CLK_H_DIV64: cnt_tick = ticks.div64;
			`CPT_CLK_SUB_A: cnt_tick = sub_sync & ~sub_prev;
			`CPT_CLK_SUB_B: cnt_tick = sub_sync & ~sub_prev;
			`CPT_CLK_EXT_RISE: cnt_tick = ext_sync & ~ext_prev;
			`CPT_CLK_EXT_FALL: cnt_tick = ~ext_sync & ext_prev;
			default: cnt_tick = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Comparators and counter control.

	assign a_hit = (counter == compare_a_value);
	// Period code n matches at n*128 clocks; code zero wraps to 1023, the overflow.
	assign p_hit = (counter[9:7] == (ctl0.period_compare_bits - 3'h1)) && (&counter[6:0]);
	assign run = ctl0.on & ~ctl0.pause;
	assign step = cnt_tick & run;

	always_comb
	begin
		if (ctl1.mode_field == CPT_MODE_PWM)
			clr_now = ctl1.duty_swap ? a_hit : p_hit;
		else
			clr_now = ctl1.clear_select ? a_hit : p_hit;
	end

	always_comb
	begin
		if (ctl1.duty_swap)
			duty_active = (counter[9:7] < ctl0.period_compare_bits);
		else
			duty_active = (counter < compare_a_value);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus address phase capture and read timing.

	assign wr_en = dp.valid & dp.write;
	assign rd_now = dp.valid & ~dp.write & ~hreadyout;
	assign wr_ctl0 = wr_en && (dp.addr == `CPT_OFS_CTL0);
	assign on_rise = wr_ctl0 & hwdata[`CPT_CTL0_ON_BIT] & ~ctl0.on;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			dp <= '0;
		else if (hready)
		begin
			dp.valid <= hsel & htrans[1];
			dp.write <= hwrite;
			dp.addr <= {haddr[4:2], 2'h0};
		end
	end

	// Reads take one wait state so that a write just before them has landed.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			hreadyout <= 1'b1;
		else if (hready && hsel && htrans[1] && !hwrite)
			hreadyout <= 1'b0;
		else
			hreadyout <= 1'b1;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	always_comb
	begin
		case (dp.addr)
			`CPT_OFS_CTL0: rd_val = ctl0;
			`CPT_OFS_CTL1: rd_val = ctl1;
			`CPT_OFS_CNT_LO: rd_val = hold_buf;
			`CPT_OFS_CNT_HI: rd_val = {6'h00, counter[9:8]};
			`CPT_OFS_CMPA_LO: rd_val = hold_buf;
			`CPT_OFS_CMPA_HI: rd_val = {6'h00, compare_a_value[9:8]};
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			hrdata <= 32'h00000000;
		else if (rd_now)
			hrdata <= {24'h000000, rd_val};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			ctl0 <= `CPT_CTL0_RESET;
		else if (wr_ctl0)
			ctl0 <= hwdata[7:0];
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			ctl1 <= `CPT_CTL1_RESET;
		else if (wr_en && dp.addr == `CPT_OFS_CTL1)
			ctl1 <= hwdata[7:0];
	end

	// The one buffer serves both register pairs.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			hold_buf <= `CPT_BUF_RESET;
		else if (wr_en && dp.addr == `CPT_OFS_CMPA_LO)
			hold_buf <= hwdata[7:0];
		else if (rd_now && dp.addr == `CPT_OFS_CNT_HI)
			hold_buf <= counter[7:0];
		else if (rd_now && dp.addr == `CPT_OFS_CMPA_HI)
			hold_buf <= compare_a_value[7:0];
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			compare_a_value <= `CPT_CMPA_RESET;
		else if (wr_en && dp.addr == `CPT_OFS_CMPA_HI)
			compare_a_value <= {hwdata[1:0], hold_buf};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter, match requests and outputs.

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			counter <= `CPT_CNT_RESET;
		else if (on_rise)
			counter <= 10'h000;
		else if (step)
			counter <= clr_now ? 10'h000 : counter + 10'h001;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			{match_a_irq, match_p_irq} <= 2'h0;
		else
			{match_a_irq, match_p_irq} <= {step & a_hit, step & p_hit};
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			out_lvl <= 1'b0;
		else if (on_rise && ctl1.mode_field != CPT_MODE_TIMER)
			out_lvl <= ctl1.output_initial_level;
		else if (ctl1.mode_field == CPT_MODE_CMP && step && a_hit)
		begin
			case (ctl1.out_func)
				`CPT_IO_LOW: out_lvl <= 1'b0;
				`CPT_IO_HIGH: out_lvl <= 1'b1;
				`CPT_IO_TOGGLE: out_lvl <= ~out_lvl;
				default: out_lvl <= out_lvl;
			endcase
		end
		else if (ctl1.mode_field == CPT_MODE_PWM && ctl0.on)
		begin
			case (ctl1.out_func)
				`CPT_IO_PWM_OFF: out_lvl <= ~ctl1.output_initial_level;
				`CPT_IO_PWM_ON: out_lvl <= ctl1.output_initial_level;
				`CPT_IO_PWM_RUN: out_lvl <= duty_active ? ctl1.output_initial_level : ~ctl1.output_initial_level;
				default: out_lvl <= out_lvl;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			{timer_out, timer_out_n} <= 2'h1;
		else
			{timer_out, timer_out_n} <= {out_lvl ^ ctl1.polarity, ~(out_lvl ^ ctl1.polarity)};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_on_rise;
		$rose(ctl0.on);
	endsequence

	property p_out_inverse;
		timer_out_n == !timer_out;
	endproperty
	a_out_inverse: assert property (p_out_inverse) else $error("Inverted pin differs from true pin.");
	property p_on_clear;
		s_on_rise |-> counter == 10'h000;
	endproperty
	a_on_clear: assert property (p_on_clear) else $error("Counter not cleared on counter-on rise.");
	property p_init_level;
		s_on_rise and ($past(ctl1.mode_field) != CPT_MODE_TIMER) |-> out_lvl == $past(ctl1.output_initial_level);
	endproperty
	a_init_level: assert property (p_init_level) else $error("Output not at initial level after turn-on.");
	property p_pause_hold;
		ctl0.pause && !wr_ctl0 |=> $stable(counter);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("Counter moved while paused.");
	property p_off_hold;
		!ctl0.on && !wr_ctl0 |=> $stable(counter);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("Counter moved while off.");
	property p_count_up;
		step && !clr_now && !on_rise |=> counter == $past(counter) + 10'h001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("Counter did not advance by one.");
	property p_clear_a;
		step && a_hit && ctl1.clear_select && ctl1.mode_field != CPT_MODE_PWM |=> counter == 10'h000;
	endproperty
	a_clear_a: assert property (p_clear_a) else $error("Counter not cleared on A match.");
	property p_overflow;
		step && counter == 10'h3FF && ctl0.period_compare_bits == 3'h0 |=> counter == 10'h000 && match_p_irq;
	endproperty
	a_overflow: assert property (p_overflow) else $error("Overflow did not wrap with a P request.");
	property p_a_request;
		step && counter == compare_a_value |=> match_a_irq;
	endproperty
	a_a_request: assert property (p_a_request) else $error("Missing A match request.");
	property p_div4_tick;
		ticks.div4 |=> (!ticks.div4) [*3] ##1 ticks.div4;
	endproperty
	a_div4_tick: assert property (p_div4_tick) else $error("Quarter-rate tick not every fourth cycle.");
	property p_cmpa_write;
		wr_en && dp.addr == `CPT_OFS_CMPA_HI |=> compare_a_value == {$past(hwdata[1:0]), $past(hold_buf)};
	endproperty
	a_cmpa_write: assert property (p_cmpa_write) else $error("Compare A pair not loaded from buffer.");
	property p_lo_write;
		wr_en && dp.addr == `CPT_OFS_CMPA_LO |=> $stable(compare_a_value);
	endproperty
	a_lo_write: assert property (p_lo_write) else $error("Low write changed compare A.");
	property p_hi_read;
		rd_now && dp.addr == `CPT_OFS_CNT_HI |=> hold_buf == $past(counter[7:0]) && hreadyout;
	endproperty
	a_hi_read: assert property (p_hi_read) else $error("Counter high read did not snapshot.");
	property p_toggle;
		ctl1.mode_field == CPT_MODE_CMP && ctl1.out_func == `CPT_IO_TOGGLE && step && a_hit && !on_rise
			|=> out_lvl != $past(out_lvl);
	endproperty
	a_toggle: assert property (p_toggle) else $error("Output did not toggle on A match.");

endmodule
`default_nettype wire

/* test_compact_timer_10bit.sv */
// Self-checking testbench for the compact 10-bit timer.
// Assumes cpt_pkg and cpt_timer are compiled first; the bench is the only bus master.
`timescale 1ns/1ps
`default_nettype none

module test_compact_timer_10bit;
	typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data;} cpt_tb_reg_t;
	typedef struct packed {logic [7:0] ctl1; logic [7:0] ctl0; logic sel_p; logic [15:0] period;} cpt_tb_tim_t;
	typedef struct packed {logic [7:0] ctl1; logic [2:0] lv;} cpt_tb_out_t;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic ext_clock_pin = 1'b0;
	logic sub_clock_pin = 1'b0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic timer_out;
	logic timer_out_n;
	logic match_a_irq;
	logic match_p_irq;
	logic [7:0] q;
	logic [9:0] v1;
	logic [9:0] v2;
	int err_total = 0;
	int n_checks = 0;
	int pin_cnt = 0;
	int hi_cnt;
	cpt_tb_reg_t reg_rows [24] = '{
		'{1'b0, 8'h00, 8'h00}, '{1'b0, 8'h04, 8'h00}, '{1'b0, 8'h0C, 8'h00}, '{1'b0, 8'h08, 8'h00},
		'{1'b0, 8'h14, 8'h00}, '{1'b0, 8'h10, 8'h00}, '{1'b1, 8'h04, 8'hC1}, '{1'b0, 8'h04, 8'hC1},
		'{1'b1, 8'h00, 8'h07}, '{1'b0, 8'h00, 8'h07}, '{1'b1, 8'h10, 8'h5A}, '{1'b1, 8'h14, 8'hFF},
		'{1'b0, 8'h14, 8'h03}, '{1'b0, 8'h10, 8'h5A}, '{1'b1, 8'h10, 8'h09}, '{1'b1, 8'h14, 8'h00},
		'{1'b0, 8'h14, 8'h00}, '{1'b0, 8'h10, 8'h09}, '{1'b1, 8'h08, 8'h55}, '{1'b1, 8'h0C, 8'h03},
		'{1'b0, 8'h0C, 8'h00}, '{1'b0, 8'h08, 8'h00}, '{1'b1, 8'h18, 8'hFF}, '{1'b0, 8'h18, 8'h00}};
	cpt_tb_tim_t tim_rows [12] = '{
		'{8'hC1, 8'h19, 1'b0, 16'd10}, '{8'hC0, 8'h19, 1'b0, 16'd128}, '{8'hC0, 8'h18, 1'b1, 16'd1024},
		'{8'hC0, 8'h19, 1'b1, 16'd128}, '{8'hC0, 8'h1F, 1'b1, 16'd896}, '{8'hC0, 8'h09, 1'b1, 16'd512},
		'{8'hC0, 8'h29, 1'b1, 16'd2048}, '{8'hC0, 8'h39, 1'b1, 16'd8192}, '{8'hC0, 8'h49, 1'b1, 16'd1024},
		'{8'hC0, 8'h59, 1'b1, 16'd1024}, '{8'hC0, 8'h69, 1'b1, 16'd768}, '{8'hC0, 8'h79, 1'b1, 16'd768}};
	cpt_tb_out_t out_rows [6] = '{'{8'h31, 3'b010}, '{8'h19, 3'b100}, '{8'h21, 3'b011}, '{8'h35, 3'b101},
		'{8'h98, 3'h7}, '{8'h88, 3'h0}};

	cpt_timer dut_u
	(
		.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .ext_clock_pin(ext_clock_pin), .sub_clock_pin(sub_clock_pin),
		.timer_out(timer_out), .timer_out_n(timer_out_n), .match_a_irq(match_a_irq), .match_p_irq(match_p_irq)
	);

////////////////////////////////////////////////////////////////////////////////

	initial
	begin
		forever #2.5 mclk = ~mclk;
	end

	// External pin has a 6-cycle period, the sub clock pin an 8-cycle period.
	always @(posedge mclk)
	begin
		pin_cnt <= pin_cnt + 1;
		if (pin_cnt % 3 == 2)
			ext_clock_pin <= ~ext_clock_pin;
		if (pin_cnt % 4 == 3)
			sub_clock_pin <= ~sub_clock_pin;
	end

////////////////////////////////////////////////////////////////////////////////

	task end_sim;
		$display("Checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// Waits for an edge with hready high; the level is sampled half a cycle earlier.
	task wait_rdy;
		int n;
		logic r;
		n = 0;
		r = 1'b0;
		while (r !== 1'b1 && n < 50)
		begin
			@(negedge mclk);
			r = hreadyout;
			q = hrdata[7:0];
			@(posedge mclk);
			n++;
		end
		chk({31'h0, r}, 32'h1);
	endtask

	task ahb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
		chk({31'h0, hresp}, 32'h0);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp);
		ahb(1'b0, a, 8'h00);
		chk({24'h0, q}, {24'h0, exp});
	endtask

	task rdcnt(output logic [9:0] v);
		ahb(1'b0, 8'h0C, 8'h00);
		v[9:8] = q[1:0];
		ahb(1'b0, 8'h08, 8'h00);
		v[7:0] = q;
	endtask

	// Skips to one irq pulse, then counts the cycles to the next one.
	task per(input logic sel_p, input int exp);
		int n;
		logic v;
		for (int i = 0; i < 2; i++)
		begin
			n = 0;
			v = 1'b0;
			while (v !== 1'b1 && n < 20000)
			begin
				@(negedge mclk);
				v = sel_p ? match_p_irq : match_a_irq;
				n++;
			end
		end
		@(posedge mclk);
		chk(n, exp);
	endtask

	task lvl(input int n, input logic e);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
		chk({31'h0, timer_out}, {31'h0, e});
		chk({31'h0, timer_out_n}, {31'h0, ~e});
		@(posedge mclk);
	endtask

////////////////////////////////////////////////////////////////////////////////

	initial
	begin
		repeat (80000) @(posedge mclk);
		err_total++;
		$display("Error at %0t: timeout", $time);
		end_sim();
	end

	initial
	begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		foreach (reg_rows[i])
		begin
			if (reg_rows[i].wr)
				ahb(1'b1, reg_rows[i].addr, reg_rows[i].data);
			else
				rd(reg_rows[i].addr, reg_rows[i].data);
		end
		ahb(1'b1, 8'h04, 8'hC0);
		ahb(1'b1, 8'h00, 8'h18);
		repeat (40) @(posedge mclk);
		ahb(1'b1, 8'h00, 8'h98);
		rdcnt(v1);
		repeat (20) @(posedge mclk);
		rdcnt(v2);
		chk({22'h0, v2}, {22'h0, v1});
		chk({31'h0, v1 >= 10'd40}, 32'h1);
		ahb(1'b1, 8'h00, 8'h18);
		repeat (200) @(posedge mclk);
		ahb(1'b1, 8'h00, 8'h10);
		rdcnt(v1);
		chk({31'h0, v1 >= v2 + 10'd200}, 32'h1);
		repeat (20) @(posedge mclk);
		rdcnt(v2);
		chk({22'h0, v2}, {22'h0, v1});
		ahb(1'b1, 8'h00, 8'h18);
		rdcnt(v1);
		chk({31'h0, v1 < 10'd16}, 32'h1);
		foreach (tim_rows[i])
		begin
			ahb(1'b1, 8'h00, 8'h00);
			ahb(1'b1, 8'h04, tim_rows[i].ctl1);
			ahb(1'b1, 8'h00, tim_rows[i].ctl0);
			per(tim_rows[i].sel_p, tim_rows[i].period);
		end
		foreach (out_rows[i])
		begin
			ahb(1'b1, 8'h00, 8'h00);
			ahb(1'b1, 8'h04, out_rows[i].ctl1);
			ahb(1'b1, 8'h00, 8'h18);
			lvl(3, out_rows[i].lv[2]);
			lvl(11, out_rows[i].lv[1]);
			lvl(10, out_rows[i].lv[0]);
		end
		ahb(1'b1, 8'h00, 8'h00);
		ahb(1'b1, 8'h04, 8'hA8);
		ahb(1'b1, 8'h00, 8'h19);
		repeat (20) @(posedge mclk);
		hi_cnt = 0;
		repeat (256)
		begin
			@(negedge mclk);
			if (timer_out === 1'b1)
				hi_cnt++;
		end
		@(posedge mclk);
		chk(hi_cnt, 18);
		rst <= 1'b1;
		@(negedge mclk);
		chk({29'h0, hreadyout, timer_out, timer_out_n}, 32'h5);
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(8'h04, 8'h00);
		rdcnt(v1);
		chk({22'h0, v1}, 32'h0);
		end_sim();
	end
endmodule

`default_nettype wire
